// File: hdl/fwpm_pkg.sv
// Constants and field layout of the fail-safe watchdog and power-mode block
`default_nettype none
package fwpm_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam logic [7:0] OFF_POWER_CONTROL_REG     = 8'h00;  // Power control register
   localparam logic [7:0] OFF_WD_CTRL  = 8'h04;  // Watchdog refresh/start/cause
   localparam logic [7:0] OFF_WD_REL   = 8'h08;  // Reload value and rate select
   localparam logic [7:0] OFF_WD_CNT   = 8'h0c;  // Live watchdog count, read only
   localparam logic [7:0] OFF_STATUS   = 8'h10;  // Power/supervisor state, read only
   // Power control field positions
   localparam int POWER_CONTROL_REG_IDLE_ARM  = 0;            // First idle step, pattern 01h
   localparam int POWER_CONTROL_REG_PD_ARM    = 1;            // First power-down step, pattern 02h
   localparam int POWER_CONTROL_REG_SLOW      = 4;            // Slow-down, set 10h, clear with 0EFh
   localparam int POWER_CONTROL_REG_IDLE_GO   = 5;            // Second idle step, pattern 20h
   localparam int POWER_CONTROL_REG_PD_GO     = 6;            // Second power-down step, pattern 40h
   localparam logic [7:0] POWER_CONTROL_REG_KEEP_MASK = 8'h9c; // Trigger bits are not stored
   localparam logic [7:0] POWER_CONTROL_REG_RESET     = 8'h00;
   // Watchdog control field positions
   localparam int WDC_REFRESH = 0;               // wd_refresh_bit, write only
   localparam int WDC_START   = 1;               // wd_start_bit, write only
   localparam int WDC_CAUSE   = 2;               // wd_reset_cause_flag, read only
   localparam int WDC_RUN     = 3;               // Running, read only
   localparam int WDR_RATE    = 7;               // Rate select in reload register
   localparam logic [6:0] WD_RELOAD_RESET = 7'h00;
   // Watchdog geometry and prescale
   localparam int WD_BITS     = 15;
   localparam int WD_REL_BITS = 7;
   localparam logic [7:0] PRE_DIV_FAST = 8'h0c;  // Oscillator / 12
   localparam logic [7:0] PRE_DIV_SLOW = 8'hc0;  // Oscillator / 192
   localparam logic [4:0] SLOW_DIV_LAST = 5'h1f; // Slow-down divides by 32
   localparam logic [3:0] WD_RST_CYCLES = 4'h8;  // Length of watchdog chip reset
   // Oscillator stabilisation time
   localparam int CLK_FREQ_KHZ = 25000;          // 25 MHz system clock
   localparam int STAB_TIME_US = 1000;           // Typically 1 ms
   localparam int STAB_CYCLES  = (STAB_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
   // Oscillator supervisor states, Gray along hold, stabilise, run
   typedef enum logic [1:0] {
      SUP_HOLD = 2'b00,
      SUP_STAB = 2'b01,
      SUP_RUN  = 2'b11,
      SUP_SWPD = 2'b10
   } fwpm_sup_t;
endpackage
`default_nettype wire

// File: hdl/fwpm_top.sv
// Watchdog timer, oscillator supervisor and power modes with Avalon-MM registers
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`default_nettype none
module fwpm_top #(
   parameter int STAB_CYC = fwpm_pkg::STAB_CYCLES  // Stabilisation count, shorten in simulation
) (
   input  wire logic        clock,                  // 25 MHz oscillator clock
   input  wire logic        arst_n,                 // External reset, asynchronous
   input  wire logic [7:0]  avs_address,            // Byte address
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        wd_hw_start_pin,        // High starts the watchdog
   input  wire logic        main_osc_slow,          // Main oscillator below RC frequency
   input  wire logic        hw_powerdown_pin_n,     // Low enters hardware power-down
   input  wire logic        wake_pin_n,             // Low level wakes from software power-down
   input  wire logic        can_receive_wake_pin_n, // Second wake source, active low
   input  wire logic        periph_irq,             // Any peripheral interrupt, ends idle
   output logic             chip_reset,             // Internal chip reset request
   output logic             clk_sel_rc,             // Internal clock taken from RC
   output logic             main_osc_en,            // Main oscillator running
   output logic             rc_osc_en,              // RC oscillator running
   output logic             ports_float,            // Ports released in hardware power-down
   output logic             cpu_clk_en,             // CPU clock enable pulse
   output logic             periph_clk_en,          // Peripheral clock enable pulse
   output logic             wake_irq                // Wake-up interrupt, one cycle
);

   //////////////////////////////////////////////////////////////////////////////
   // State of the whole block in one record
   typedef struct packed {
      fwpm_pkg::fwpm_sup_t sup;        // Supervisor state
      logic [15:0]         stab_cnt;   // Stabilisation counter
      logic                wake;       // Stabilising after a software wake
      logic [7:0]          power_control_reg;       // Stored power control bits
      logic                idle_arm;   // First idle step seen
      logic                pd_arm;     // First power-down step seen
      logic                idle;       // Idle mode active
      logic                swpd;       // Software power-down requested
      logic [14:0]         wd_cnt;     // Watchdog counter
      logic                wd_run;     // Watchdog running
      logic                wd_armed;   // Refresh bit written by previous write
      logic [6:0]          wd_rel;     // Reload value
      logic                wd_rate;    // Selects the slow prescale
      logic                wd_cause;   // Watchdog reset seen since the last external reset
      logic [7:0]          wd_pre;     // Prescaler
      logic [3:0]          wd_rst;     // Watchdog reset cycles left
      logic [4:0]          div;        // Slow-down divider
      logic                ack;        // Bus answer phase
      logic [31:0]         rdata;      // Read data
      logic                wake_irq;   // Wake interrupt pulse
   } fwpm_state_t;

   fwpm_state_t s_ff;                  // Registered state
   fwpm_state_t nxt_s;                 // Next state

   //////////////////////////////////////////////////////////////////////////////
   // Decoded conditions shared by the next-state logic and the checks
   logic        osc_on;                // Oscillators powered
   logic        slow_tick;             // Slow-down divider lets this cycle through
   logic        per_en;                // Peripheral enable this cycle
   logic        wd_tick;               // Watchdog increments this cycle
   logic        wd_ovf;                // Watchdog overflows this cycle
   logic        wr_en;                 // Write taken this cycle
   logic [7:0]  wdat;                  // Low byte of write data
   logic        refresh_go;            // Second half of refresh sequence
   logic        start_req;             // Start requested by pin or software
   logic [7:0]  pre_lim;               // Prescale limit
   logic [31:0] rd_val;                // Read value by address
   logic        rst_c;                 // Combinational chip reset

   // Enables, bus qualification and read mux
   always_comb begin
      osc_on     = hw_powerdown_pin_n && (s_ff.sup != fwpm_pkg::SUP_SWPD);
      slow_tick  = !s_ff.power_control_reg[fwpm_pkg::POWER_CONTROL_REG_SLOW] || (s_ff.div == 5'h00);
      per_en     = (s_ff.sup == fwpm_pkg::SUP_RUN) && slow_tick;
      rst_c      = (s_ff.sup == fwpm_pkg::SUP_HOLD) || ((s_ff.sup == fwpm_pkg::SUP_STAB) && !s_ff.wake) ||
                   (s_ff.wd_rst != 4'h0) || !hw_powerdown_pin_n;
      pre_lim    = s_ff.wd_rate ? fwpm_pkg::PRE_DIV_SLOW : fwpm_pkg::PRE_DIV_FAST;
      // Frozen while idle or powered down: ticks need the CPU active
      wd_tick    = per_en && !s_ff.idle && !s_ff.swpd && s_ff.wd_run && !rst_c &&
                   (s_ff.wd_pre == pre_lim - 8'h01);
      wd_ovf     = wd_tick && (s_ff.wd_cnt == 15'h7fff);
      wr_en      = avs_write && s_ff.ack && avs_byteenable[0] && !rst_c;
      wdat       = avs_writedata[7:0];
      // The refresh bit alone does nothing; the start bit must follow at once
      refresh_go = wr_en && (avs_address == fwpm_pkg::OFF_WD_CTRL) && s_ff.wd_armed &&
                   wdat[fwpm_pkg::WDC_START];
      start_req  = !rst_c && (wd_hw_start_pin ||
                   (wr_en && (avs_address == fwpm_pkg::OFF_WD_CTRL) && wdat[fwpm_pkg::WDC_START]));
      // Address decode; unmapped offsets read as zero
      if (avs_address == fwpm_pkg::OFF_POWER_CONTROL_REG) begin
         rd_val = {24'h000000, s_ff.power_control_reg};
      end else if (avs_address == fwpm_pkg::OFF_WD_CTRL) begin
         rd_val = {28'h0000000, s_ff.wd_run, s_ff.wd_cause, 2'h0};
      end else if (avs_address == fwpm_pkg::OFF_WD_REL) begin
         rd_val = {24'h000000, s_ff.wd_rate, s_ff.wd_rel};
      end else if (avs_address == fwpm_pkg::OFF_WD_CNT) begin
         rd_val = {17'h00000, s_ff.wd_cnt};
      end else if (avs_address == fwpm_pkg::OFF_STATUS) begin
         rd_val = {26'h0000000, s_ff.wake, s_ff.sup, s_ff.power_control_reg[fwpm_pkg::POWER_CONTROL_REG_SLOW], s_ff.swpd, s_ff.idle};
      end else begin
         rd_val = 32'h00000000;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      nxt_s          = s_ff;
      nxt_s.wake_irq = 1'b0;
      // Bus: one wait cycle, then the answer edge
      nxt_s.ack = (avs_read || avs_write) && !s_ff.ack;
      if (avs_read && !s_ff.ack) begin
         nxt_s.rdata = rd_val;
      end
      // Slow-down divider runs whenever the oscillator does
      if (osc_on) begin
         nxt_s.div = s_ff.div + 5'h01;
      end

      // Oscillator supervisor
      case (s_ff.sup)
         fwpm_pkg::SUP_HOLD: begin
            // Clocked from RC at power-on or after a failure
            nxt_s.stab_cnt = 16'h0000;
            nxt_s.wake     = 1'b0;
            if (hw_powerdown_pin_n && !main_osc_slow) begin
               nxt_s.sup = fwpm_pkg::SUP_STAB;
            end
         end
         fwpm_pkg::SUP_STAB: begin
            if (!hw_powerdown_pin_n || main_osc_slow) begin
               nxt_s.sup = fwpm_pkg::SUP_HOLD;
            end else if (s_ff.stab_cnt == 16'(STAB_CYC - 1)) begin
               nxt_s.sup      = fwpm_pkg::SUP_RUN;
               nxt_s.wake_irq = s_ff.wake;
               nxt_s.wake     = 1'b0;
            end else begin
               nxt_s.stab_cnt = s_ff.stab_cnt + 16'h0001;
            end
         end
         fwpm_pkg::SUP_RUN: begin
            nxt_s.stab_cnt = 16'h0000;
            if (!hw_powerdown_pin_n || main_osc_slow) begin
               nxt_s.sup = fwpm_pkg::SUP_HOLD;
            end else if (s_ff.swpd) begin
               nxt_s.sup = fwpm_pkg::SUP_SWPD;
            end
         end
         fwpm_pkg::SUP_SWPD: begin
            // Both oscillators stopped; a low wake level restarts them
            if (!hw_powerdown_pin_n) begin
               nxt_s.sup = fwpm_pkg::SUP_HOLD;
            end else if (!wake_pin_n || !can_receive_wake_pin_n) begin
               nxt_s.sup  = fwpm_pkg::SUP_STAB;
               nxt_s.wake = 1'b1;
               nxt_s.swpd = 1'b0;
            end
         end
         default: begin
            nxt_s.sup = fwpm_pkg::SUP_HOLD;
         end
      endcase

      // Idle ends on any peripheral interrupt
      if (periph_irq) begin
         nxt_s.idle = 1'b0;
      end

      // Watchdog prescaler and counter
      if (per_en && !s_ff.idle && !s_ff.swpd && s_ff.wd_run) begin
         nxt_s.wd_pre = (s_ff.wd_pre == pre_lim - 8'h01) ? 8'h00 : s_ff.wd_pre + 8'h01;
      end
      if (wd_ovf) begin
         nxt_s.wd_cause = 1'b1;
         nxt_s.wd_rst   = fwpm_pkg::WD_RST_CYCLES;
      end else if (wd_tick) begin
         nxt_s.wd_cnt = s_ff.wd_cnt + 15'h0001;
      end else if (s_ff.wd_rst != 4'h0) begin
         nxt_s.wd_rst = s_ff.wd_rst - 4'h1;
      end
      // Software has no path that clears the run bit
      if (start_req && !wd_ovf) begin
         nxt_s.wd_run = 1'b1;
      end
      if (refresh_go && !wd_ovf) begin
         // Reload wins over a same-cycle tick; low bits restart from zero
         nxt_s.wd_cnt = {s_ff.wd_rel, 8'h00};
         nxt_s.wd_pre = 8'h00;
      end

      // Register writes
      if (wr_en) begin
         nxt_s.wd_armed = 1'b0;
         if (avs_address == fwpm_pkg::OFF_POWER_CONTROL_REG) begin
            nxt_s.power_control_reg     = wdat & fwpm_pkg::POWER_CONTROL_REG_KEEP_MASK;
            nxt_s.idle_arm = wdat[fwpm_pkg::POWER_CONTROL_REG_IDLE_ARM] && !wdat[fwpm_pkg::POWER_CONTROL_REG_IDLE_GO];
            nxt_s.pd_arm   = wdat[fwpm_pkg::POWER_CONTROL_REG_PD_ARM] && !wdat[fwpm_pkg::POWER_CONTROL_REG_PD_GO];
            if (s_ff.idle_arm && wdat[fwpm_pkg::POWER_CONTROL_REG_IDLE_GO]) begin
               nxt_s.idle = 1'b1;
            end
            if (s_ff.pd_arm && wdat[fwpm_pkg::POWER_CONTROL_REG_PD_GO]) begin
               nxt_s.swpd = 1'b1;
            end
         end else begin
            nxt_s.idle_arm = 1'b0;
            nxt_s.pd_arm   = 1'b0;
            if (avs_address == fwpm_pkg::OFF_WD_CTRL) begin
               nxt_s.wd_armed = wdat[fwpm_pkg::WDC_REFRESH];
            end else if (avs_address == fwpm_pkg::OFF_WD_REL) begin
               nxt_s.wd_rel  = wdat[6:0];
               nxt_s.wd_rate = wdat[fwpm_pkg::WDR_RATE];
            end
         end
      end

      // Internal reset: power modes return to default, watchdog stops cleared
      if (rst_c) begin
         nxt_s.power_control_reg     = fwpm_pkg::POWER_CONTROL_REG_RESET;
         nxt_s.idle     = 1'b0;
         nxt_s.swpd     = 1'b0;
         nxt_s.idle_arm = 1'b0;
         nxt_s.pd_arm   = 1'b0;
         nxt_s.wd_cnt   = 15'h0000;
         nxt_s.wd_pre   = 8'h00;
         nxt_s.wd_run   = 1'b0;
         nxt_s.wd_armed = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // State register; external reset also clears the watchdog cause flag
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '{sup: fwpm_pkg::SUP_HOLD, power_control_reg: fwpm_pkg::POWER_CONTROL_REG_RESET, wd_rel: fwpm_pkg::WD_RELOAD_RESET,
                   default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_comb begin
      avs_waitrequest = (avs_read || avs_write) && !s_ff.ack;
      avs_readdata    = s_ff.rdata;
      chip_reset      = rst_c;
      clk_sel_rc      = (s_ff.sup == fwpm_pkg::SUP_HOLD);
      main_osc_en     = osc_on;
      rc_osc_en       = osc_on;
      ports_float     = !hw_powerdown_pin_n;
      periph_clk_en   = per_en;
      cpu_clk_en      = per_en && !s_ff.idle && !rst_c;
      wake_irq        = s_ff.wake_irq;
   end

   //////////////////////////////////////////////////////////////////////////////
   // Checks
   localparam int STAB_LAST = STAB_CYC - 1;

   sequence s_overflow;
      wd_ovf && !refresh_go;
   endsequence

   sequence s_wd_reset_held;
      chip_reset [*8];
   endsequence

   property p_wd_overflow_reset;
      @(posedge clock) disable iff (!arst_n) s_overflow |=> s_wd_reset_held ##1 (s_ff.wd_cnt == 15'h0000);
   endproperty
   a_wd_overflow_reset: assert property (p_wd_overflow_reset) else $error("Overflow did not reset");

   property p_refresh_reload;
      @(posedge clock) disable iff (!arst_n) (refresh_go && !wd_ovf && !rst_c) |=>
         (s_ff.wd_cnt == {$past(s_ff.wd_rel), 8'h00});
   endproperty
   a_refresh_reload: assert property (p_refresh_reload) else $error("Refresh did not reload count");

   property p_freeze;
      @(posedge clock) disable iff (!arst_n) (s_ff.idle && !rst_c && !refresh_go) |=> $stable(s_ff.wd_cnt);
   endproperty
   a_freeze: assert property (p_freeze) else $error("Watchdog moved while idle");

   property p_no_stop;
      @(posedge clock) disable iff (!arst_n) (s_ff.wd_run && !rst_c && !wd_ovf) |=> s_ff.wd_run;
   endproperty
   a_no_stop: assert property (p_no_stop) else $error("Watchdog stopped while active");

   property p_start;
      @(posedge clock) disable iff (!arst_n) (wd_hw_start_pin && !rst_c && !wd_ovf) |=> s_ff.wd_run;
   endproperty
   a_start: assert property (p_start) else $error("Start pin ignored");

   property p_osc_fail;
      @(posedge clock) disable iff (!arst_n) (s_ff.sup == fwpm_pkg::SUP_RUN && main_osc_slow) |=>
         (chip_reset && clk_sel_rc);
   endproperty
   a_osc_fail: assert property (p_osc_fail) else $error("Oscillator failure not caught");

   property p_stab_release;
      @(posedge clock) disable iff (!arst_n)
         (s_ff.sup == fwpm_pkg::SUP_STAB && s_ff.stab_cnt == 16'(STAB_LAST) && hw_powerdown_pin_n && !main_osc_slow)
         |=> (s_ff.sup == fwpm_pkg::SUP_RUN) && (wake_irq == $past(s_ff.wake));
   endproperty
   a_stab_release: assert property (p_stab_release) else $error("Stabilisation end missed");

   property p_idle_entry;
      @(posedge clock) disable iff (!arst_n)
         (wr_en && avs_address == fwpm_pkg::OFF_POWER_CONTROL_REG && s_ff.idle_arm && wdat[fwpm_pkg::POWER_CONTROL_REG_IDLE_GO] && !periph_irq)
         |=> s_ff.idle && !cpu_clk_en;
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("Idle not entered");

   property p_swpd_osc_off;
      @(posedge clock) disable iff (!arst_n) (s_ff.sup == fwpm_pkg::SUP_SWPD) |-> (!main_osc_en && !rc_osc_en);
   endproperty
   a_swpd_osc_off: assert property (p_swpd_osc_off) else $error("Oscillator ran in power-down");

   property p_hw_powerdown_pin;
      @(posedge clock) disable iff (!arst_n) !hw_powerdown_pin_n |-> (chip_reset && ports_float && !main_osc_en);
   endproperty
   a_hw_powerdown_pin: assert property (p_hw_powerdown_pin) else $error("Hardware power-down not held");

   property p_slow;
      @(posedge clock) disable iff (!arst_n) (s_ff.power_control_reg[fwpm_pkg::POWER_CONTROL_REG_SLOW] && periph_clk_en && hw_powerdown_pin_n)
         |=> (!periph_clk_en || !s_ff.power_control_reg[fwpm_pkg::POWER_CONTROL_REG_SLOW]) [*8];
   endproperty
   a_slow: assert property (p_slow) else $error("Slow-down divider wrong");

   // Any internal reset leaves the watchdog cleared and stopped
   property p_reset_clears;
      @(posedge clock) disable iff (!arst_n) rst_c |=> (!s_ff.wd_run && (s_ff.wd_cnt == 15'h0000));
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("Watchdog survived reset");

   // A peripheral interrupt ends idle unless a write re-enters it
   property p_idle_exit;
      @(posedge clock) disable iff (!arst_n) (s_ff.idle && periph_irq && !wr_en) |=> !s_ff.idle;
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("Interrupt did not end idle");

   // A low wake level restarts the oscillators without a chip reset
   property p_wake_start;
      @(posedge clock) disable iff (!arst_n)
         (s_ff.sup == fwpm_pkg::SUP_SWPD && hw_powerdown_pin_n && !wake_pin_n) |=>
         (s_ff.sup == fwpm_pkg::SUP_STAB) && s_ff.wake;
   endproperty
   a_wake_start: assert property (p_wake_start) else $error("Wake pin did not restart");

endmodule
`default_nettype wire

// File: testbench/fwpm_pins_model.sv
// Behavioural model of the board pins around the watchdog and power-mode block
`default_nettype none
module fwpm_pins_model (
   input  wire logic clock,                  // Oscillator clock
   input  wire logic start_req,              // Hold the start pin high
   input  wire logic osc_bad,                // Main oscillator slower than RC
   input  wire logic pd_req,                 // Request hardware power-down
   input  wire logic wake_req,               // Pull the wake pin low
   input  wire logic irq_req,                // Peripheral interrupt request
   output logic      wd_hw_start_pin,
   output logic      main_osc_slow,
   output logic      hw_powerdown_pin_n,
   output logic      wake_pin_n,
   output logic      can_receive_wake_pin_n,
   output logic      periph_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] pins_ff = 5'h0e;              // Start, osc slow, pd_n, wake_n, irq; power-on with oscillator not running
   // Pins move just after an edge, as board logic clocked by the oscillator would
   always @(posedge clock) begin
      pins_ff <= {start_req, osc_bad, !pd_req, !wake_req, irq_req};
   end
   assign wd_hw_start_pin        = pins_ff[4];
   assign main_osc_slow          = pins_ff[3];
   assign hw_powerdown_pin_n     = pins_ff[2];
   assign wake_pin_n             = pins_ff[1];
   assign can_receive_wake_pin_n = 1'b1;     // Second wake source left idle, it shares the wake path
   assign periph_irq             = pins_ff[0];
endmodule
`default_nettype wire

// File: testbench/fwpm_top_tb.sv
// Self-checking bench for the watchdog, oscillator supervisor and power modes
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module fwpm_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STAB = 20;                 // Shortened stabilisation count
   logic clock = 0, arst_n = 0, avs_read = 0, avs_write = 0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic avs_waitrequest, chip_reset, clk_sel_rc, main_osc_en, rc_osc_en, ports_float, cpu_clk_en, periph_clk_en;
   logic wake_irq, start_req = 0, osc_bad = 1, pd_req = 0, wake_req = 0, irq_req = 0;
   logic wd_hw_start_pin, main_osc_slow, hw_powerdown_pin_n, wake_pin_n, can_receive_wake_pin_n, periph_irq;
   int fail_count = 0, checks = 0, n;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} fwpm_row_t;
   fwpm_row_t rows [7] = '{'{fwpm_pkg::OFF_WD_REL, 8'h85, 8'h85}, '{fwpm_pkg::OFF_WD_REL, 8'h7e, 8'h7e},
      '{fwpm_pkg::OFF_POWER_CONTROL_REG, 8'h10, 8'h10}, '{fwpm_pkg::OFF_POWER_CONTROL_REG, 8'h00, 8'h00}, '{8'h20, 8'hff, 8'h00},
      '{fwpm_pkg::OFF_WD_CNT, 8'hff, 8'h00}, '{fwpm_pkg::OFF_WD_CTRL, 8'h00, 8'h00}};
   fwpm_pins_model u_fwpm_pins_model (.clock(clock), .start_req(start_req), .osc_bad(osc_bad), .pd_req(pd_req),
      .wake_req(wake_req), .irq_req(irq_req), .wd_hw_start_pin(wd_hw_start_pin), .main_osc_slow(main_osc_slow),
      .hw_powerdown_pin_n(hw_powerdown_pin_n), .wake_pin_n(wake_pin_n),
      .can_receive_wake_pin_n(can_receive_wake_pin_n), .periph_irq(periph_irq));
   fwpm_top #(.STAB_CYC(STAB)) u_fwpm_top (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wd_hw_start_pin(wd_hw_start_pin),
      .main_osc_slow(main_osc_slow), .hw_powerdown_pin_n(hw_powerdown_pin_n), .wake_pin_n(wake_pin_n),
      .can_receive_wake_pin_n(can_receive_wake_pin_n), .periph_irq(periph_irq), .chip_reset(chip_reset),
      .clk_sel_rc(clk_sel_rc), .main_osc_en(main_osc_en), .rc_osc_en(rc_osc_en), .ports_float(ports_float),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .wake_irq(wake_irq));
   // 25 MHz oscillator
   initial begin
      forever #20 clock = !clock;
   end
   // Avalon cycle: request after an edge, held until waitrequest is sampled low at a rising edge
   // Reading right after the edge, before the design's registers update, sees the pre-edge values
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      do begin @(posedge clock); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) fail_count++;
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Count cycles until the chip leaves reset, bounded so a stuck reset ends the wait
   task automatic wait_run(input int lim);
      n = 0;
      while (chip_reset !== 1'b0 && n < lim) begin @(negedge clock); n++; end
   endtask
   task automatic finish_test();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Watchdog on the whole run, well beyond the expected ten thousand or so cycles
   initial begin
      repeat (40000) @(posedge clock);
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(negedge clock);
      `CHK("rc_clock_at_power_on", 1'b1, clk_sel_rc & chip_reset)
      osc_bad <= 1'b0;
      wait_run(200);
      `CHK("stab_after_osc_ok", 1'b1, n >= STAB)
      // Table of register writes and read-back
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d, q);
         bus(1'b0, rows[i].a, 8'h00, q);
         `CHK("reg_row", {24'h0, rows[i].e}, q)
      end
      // Slow-down: one enable in 32, then full speed after clearing
      for (int s = 0; s < 2; s++) begin
         bus(1'b1, fwpm_pkg::OFF_POWER_CONTROL_REG, s ? 8'h00 : 8'h10, q);
         n = 0;
         repeat (64) begin @(negedge clock); n += periph_clk_en; end
         `CHK("slow_enables", s ? 64 : 2, n)
      end
      // Start, then refresh with reload 7Eh at the /12 rate
      bus(1'b1, fwpm_pkg::OFF_WD_CTRL, 8'h02, q);
      bus(1'b1, fwpm_pkg::OFF_WD_CTRL, 8'h01, q);
      bus(1'b1, fwpm_pkg::OFF_WD_CTRL, 8'h02, q);
      bus(1'b0, fwpm_pkg::OFF_WD_CNT, 8'h00, q);
      `CHK("refresh_load", 7'h7e, q[14:8])
      // Idle freezes the count; an interrupt ends idle
      bus(1'b1, fwpm_pkg::OFF_POWER_CONTROL_REG, 8'h01, q);
      bus(1'b1, fwpm_pkg::OFF_POWER_CONTROL_REG, 8'h20, q);
      bus(1'b0, fwpm_pkg::OFF_WD_CNT, 8'h00, q);
      n = int'(q[14:0]);
      repeat (200) @(negedge clock);
      `CHK("idle_cpu_stopped", 1'b0, cpu_clk_en)
      bus(1'b0, fwpm_pkg::OFF_WD_CNT, 8'h00, q);
      `CHK("idle_frozen", n, int'(q[14:0]))
      irq_req <= 1'b1;
      repeat (3) @(posedge clock);
      bus(1'b0, fwpm_pkg::OFF_STATUS, 8'h00, q);
      irq_req <= 1'b0;
      `CHK("idle_left", 1'b0, q[0])
      // Software cannot stop it; a late refresh reloads it
      bus(1'b1, fwpm_pkg::OFF_WD_CTRL, 8'h00, q);
      repeat (3500) @(negedge clock);
      bus(1'b0, fwpm_pkg::OFF_WD_CTRL, 8'h00, q);
      `CHK("still_running", 1'b1, q[3])
      bus(1'b1, fwpm_pkg::OFF_WD_CTRL, 8'h01, q);
      bus(1'b1, fwpm_pkg::OFF_WD_CTRL, 8'h02, q);
      bus(1'b0, fwpm_pkg::OFF_WD_CNT, 8'h00, q);
      `CHK("second_refresh", 7'h7e, q[14:8])
      // Let it overflow: 512 steps of 12 cycles
      n = 0;
      while (chip_reset !== 1'b1 && n < 8000) begin @(negedge clock); n++; end
      `CHK("overflow_time", 1'b1, n > 5000 && n < 6300)
      wait_run(50);
      bus(1'b0, fwpm_pkg::OFF_WD_CTRL, 8'h00, q);
      `CHK("cause_after_wd", 4'h4, q[3:0])
      start_req <= 1'b1;
      repeat (3) @(posedge clock);
      bus(1'b0, fwpm_pkg::OFF_WD_CTRL, 8'h00, q);
      `CHK("pin_start", 1'b1, q[3])
      // Software power-down and wake by a short low pulse
      bus(1'b1, fwpm_pkg::OFF_POWER_CONTROL_REG, 8'h02, q);
      bus(1'b1, fwpm_pkg::OFF_POWER_CONTROL_REG, 8'h40, q);
      repeat (3) @(negedge clock);
      `CHK("pd_osc_off", 2'b00, {main_osc_en, rc_osc_en})
      wake_req <= 1'b1;
      repeat (2) @(posedge clock);
      wake_req <= 1'b0;
      n = 0;
      while (wake_irq !== 1'b1 && n < 60) begin @(negedge clock); n++; end
      `CHK("wake_delay", 1'b1, n >= STAB && n <= STAB + 4)
      // Hardware power-down, then supervised restart
      pd_req <= 1'b1;
      repeat (3) @(negedge clock);
      `CHK("hw_powerdown_pin_state", 3'b110, {chip_reset, ports_float, main_osc_en})
      pd_req <= 1'b0;
      repeat (2) @(negedge clock);
      wait_run(200);
      `CHK("hw_powerdown_pin_restart", 1'b1, n >= STAB - 2)
      // Oscillator failure switches to RC and holds reset
      osc_bad <= 1'b1;
      repeat (3) @(negedge clock);
      `CHK("osc_fail", 2'b11, {clk_sel_rc, chip_reset})
      osc_bad <= 1'b0;
      repeat (2) @(negedge clock);
      wait_run(200);
      `CHK("osc_recover", 1'b1, n >= STAB - 2)
      finish_test();
   end
endmodule
`undef CHK
`default_nettype wire
